// ### include/uac_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial core.
`ifndef UAC_REGS_SVH
`define UAC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UAC_OFF_DATA 3'h0
`define UAC_OFF_IER 3'h1
`define UAC_OFF_IIR 3'h2
`define UAC_OFF_LCR 3'h3
`define UAC_OFF_MCR 3'h4
`define UAC_OFF_LSR 3'h5
`define UAC_OFF_MSR 3'h6
`define UAC_OFF_SCR 3'h7

// ----------------------------------------------------------------------------
// Line format field positions
// ----------------------------------------------------------------------------
`define UAC_LCR_WLEN 1:0
`define UAC_LCR_STOP2 2
`define UAC_LCR_PAREN 3
`define UAC_LCR_EVEN 4
`define UAC_LCR_STICK 5
`define UAC_LCR_BREAK 6
`define UAC_LCR_DLAB 7

// ----------------------------------------------------------------------------
// Modem control field positions
// ----------------------------------------------------------------------------
`define UAC_MCR_DTR 0
`define UAC_MCR_RTS 1
`define UAC_MCR_OUT1 2
`define UAC_MCR_OUT2 3
`define UAC_MCR_LOOP 4

// ----------------------------------------------------------------------------
// Interrupt enable field positions
// ----------------------------------------------------------------------------
`define UAC_IER_RXD 0
`define UAC_IER_TX_HOLDING_EMPTY_FLAG 1
`define UAC_IER_LINE 2
`define UAC_IER_MDM 3

// ----------------------------------------------------------------------------
// Interrupt identification codes
// ----------------------------------------------------------------------------
`define UAC_IIR_NONE 8'h01
`define UAC_IIR_LINE 8'h06
`define UAC_IIR_RXD 8'h04
`define UAC_IIR_TX_HOLDING_EMPTY_FLAG 8'h02
`define UAC_IIR_MDM 8'h00

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UAC_LCR_RESET 8'h00
`define UAC_MCR_RESET 5'h00
`define UAC_IER_RESET 4'h0
`define UAC_DIV_RESET 8'h00
`define UAC_SCR_RESET 8'h00

// ----------------------------------------------------------------------------
// Bit timing in ticks of the sixteen-times clock, and word length offsets
// ----------------------------------------------------------------------------
`define UAC_TICK_MID 4'h7
`define UAC_TICK_LAST 4'hf
`define UAC_WLEN_BASE 3'h4
`define UAC_WLEN_PAD 2'h3

`endif

// ### include/uac_pkg.sv
// Types shared by the serial core and its baud generator.
package uac_pkg;

    typedef enum logic [2:0] {
        UAC_TX_IDLE = 3'h0,
        UAC_TX_START = 3'h1,
        UAC_TX_DATA = 3'h3,
        UAC_TX_PARITY = 3'h2,
        UAC_TX_STOP = 3'h6
    } uac_tx_e;

    typedef enum logic [2:0] {
        UAC_RX_IDLE = 3'h0,
        UAC_RX_START = 3'h1,
        UAC_RX_DATA = 3'h3,
        UAC_RX_PARITY = 3'h2,
        UAC_RX_STOP = 3'h6
    } uac_rx_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } uac_baud_s;

    typedef struct packed {
        logic sin1;
        logic sin2;
        logic [3:0] mdm1;
        logic [3:0] mdm2;
        logic [3:0] irq_enable_reg;
        logic [7:0] line_format_reg;
        logic [4:0] mcr;
        logic [7:0] scr;
        logic [7:0] dll;
        logic [7:0] dlm;
        logic [7:0] tx_holding_reg;
        logic thrEmpty;
        logic thriPend;
        uac_tx_e txState;
        logic [7:0] tx_shift_reg;
        logic [3:0] txCnt;
        logic [2:0] txBit;
        logic txPar;
        logic txStop2;
        logic txOut;
        uac_rx_e rxState;
        logic rxLast;
        logic [3:0] rxCnt;
        logic [2:0] rxBit;
        logic [7:0] rxShift;
        logic rxPar;
        logic rxParBad;
        logic rxZero;
        logic [7:0] rxBuf;
        logic dr;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic [3:0] mdmPrev;
        logic [3:0] mdmDelta;
        logic [7:0] rdata;
        logic serOut;
        logic baudN;
        logic rtsN;
        logic dtrN;
        logic out1N;
        logic out2N;
        logic irq;
    } uac_state_s;

endpackage : uac_pkg

// ### logic/uac_baud_gen.sv
// Programmable divider that makes the sixteen-times bit clock enable.
`timescale 1ns/1ps

module uac_baud_gen (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Divisor and enable
    input wire logic [15:0] divisor,
    output logic tick
);
    import uac_pkg::*;

    uac_baud_s b_q;
    uac_baud_s b_d;

    // A zero divisor stops the generator; a shrunk divisor restarts the count.
    always_comb begin
        b_d = b_q;
        b_d.tick = 1'b0;
        if (divisor == 16'h0000) begin
            b_d.cnt = 16'h0000;
        end else if (b_q.cnt >= divisor - 16'h0001) begin
            b_d.cnt = 16'h0000;
            b_d.tick = 1'b1;
        end else begin
            b_d.cnt = b_q.cnt + 16'h0001;
        end
        if (rst) begin
            b_d = '0;
        end
    end

    always_ff @(posedge clock) begin
        b_q <= b_d;
    end

    assign tick = b_q.tick;

endmodule : uac_baud_gen

// ### logic/uac_core.sv
// Asynchronous serial transmitter and receiver with host registers and modem lines.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "uac_regs.svh"

module uac_core (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostWdata,
    input wire logic hostWrite,
    input wire logic hostRead,
    output logic [7:0] hostRdata,
    // Serial line
    input wire logic serialIn,
    output logic serialOut,
    output logic baudOutN,
    // Modem inputs
    input wire logic ctsN,
    input wire logic dsrN,
    input wire logic dcdN,
    input wire logic riN,
    // Modem outputs
    output logic rtsN,
    output logic dtrN,
    output logic out1N,
    output logic out2N,
    // Interrupt
    output logic irqOut
);
    import uac_pkg::*;

    // ------------------------------------------------------------------------
    // State and helper terms
    // ------------------------------------------------------------------------
    uac_state_s s_q;
    uac_state_s s_d;
    logic tick;
    logic loopMode;
    logic rxLine;
    logic [3:0] mdmLvl;
    logic [2:0] lastBit;
    logic lineCond;
    logic lineInt;
    logic rxInt;
    logic txInt;
    logic mdmInt;
    logic [7:0] iirVal;
    logic [7:0] lsrVal;
    logic txParBit;
    logic rxParExp;

    uac_baud_gen baudGen (
        .clock(clock),
        .rst(rst),
        .divisor({s_q.dlm, s_q.dll}),
        .tick(tick)
    );

    assign loopMode = s_q.mcr[`UAC_MCR_LOOP];
    // In loopback the receiver hears the transmitter and the pins are ignored.
    assign rxLine = loopMode ? (s_q.txOut & ~s_q.line_format_reg[`UAC_LCR_BREAK]) : s_q.sin2;
    // Modem levels ordered carrier, ring, data-set-ready, clear-to-send.
    assign mdmLvl = loopMode ? {s_q.mcr[`UAC_MCR_OUT2], s_q.mcr[`UAC_MCR_OUT1],
                                s_q.mcr[`UAC_MCR_DTR], s_q.mcr[`UAC_MCR_RTS]}
                             : ~s_q.mdm2;
    assign lastBit = {1'b0, s_q.line_format_reg[`UAC_LCR_WLEN]} + `UAC_WLEN_BASE;
    assign txParBit = s_q.line_format_reg[`UAC_LCR_STICK] ? ~s_q.line_format_reg[`UAC_LCR_EVEN]
                    : (s_q.line_format_reg[`UAC_LCR_EVEN] ? s_q.txPar : ~s_q.txPar);
    assign rxParExp = s_q.line_format_reg[`UAC_LCR_STICK] ? ~s_q.line_format_reg[`UAC_LCR_EVEN]
                    : (s_q.line_format_reg[`UAC_LCR_EVEN] ? s_q.rxPar : ~s_q.rxPar);

    // ------------------------------------------------------------------------
    // Interrupt sources and identification
    // ------------------------------------------------------------------------
    assign lineCond = s_q.oe | s_q.pe | s_q.fe | s_q.bi;
    assign lineInt = s_q.irq_enable_reg[`UAC_IER_LINE] & lineCond;
    assign rxInt = s_q.irq_enable_reg[`UAC_IER_RXD] & s_q.dr;
    assign txInt = s_q.irq_enable_reg[`UAC_IER_TX_HOLDING_EMPTY_FLAG] & s_q.thriPend;
    assign mdmInt = s_q.irq_enable_reg[`UAC_IER_MDM] & (|s_q.mdmDelta);

    always_comb begin
        if (lineInt) begin
            iirVal = `UAC_IIR_LINE;
        end else if (rxInt) begin
            iirVal = `UAC_IIR_RXD;
        end else if (txInt) begin
            iirVal = `UAC_IIR_TX_HOLDING_EMPTY_FLAG;
        end else if (mdmInt) begin
            iirVal = `UAC_IIR_MDM;
        end else begin
            iirVal = `UAC_IIR_NONE;
        end
    end

    assign lsrVal = {1'b0, s_q.thrEmpty & (s_q.txState == UAC_TX_IDLE), s_q.thrEmpty,
                     s_q.bi, s_q.fe, s_q.pe, s_q.oe, s_q.dr};

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sin1 = serialIn;
        s_d.sin2 = s_q.sin1;
        s_d.mdm1 = {dcdN, riN, dsrN, ctsN};
        s_d.mdm2 = s_q.mdm1;
        s_d.rdata = 8'h00;

        // Host writes take the separate write-data bus.
        if (hostWrite) begin
            case (hostAddr)
                `UAC_OFF_DATA: begin
                    if (s_q.line_format_reg[`UAC_LCR_DLAB]) begin
                        s_d.dll = hostWdata;
                    end else begin
                        s_d.tx_holding_reg = hostWdata;
                        s_d.thrEmpty = 1'b0;
                        s_d.thriPend = 1'b0;
                    end
                end
                `UAC_OFF_IER: begin
                    if (s_q.line_format_reg[`UAC_LCR_DLAB]) begin
                        s_d.dlm = hostWdata;
                    end else begin
                        s_d.irq_enable_reg = hostWdata[3:0];
                    end
                end
                `UAC_OFF_LCR: s_d.line_format_reg = hostWdata;
                `UAC_OFF_MCR: s_d.mcr = hostWdata[4:0];
                `UAC_OFF_SCR: s_d.scr = hostWdata;
                default: begin
                end
            endcase
        end

        // Host reads; clears act before the hardware sets below, so a set wins.
        if (hostRead) begin
            case (hostAddr)
                `UAC_OFF_DATA: begin
                    if (s_q.line_format_reg[`UAC_LCR_DLAB]) begin
                        s_d.rdata = s_q.dll;
                    end else begin
                        s_d.rdata = s_q.rxBuf;
                        s_d.dr = 1'b0;
                    end
                end
                `UAC_OFF_IER: s_d.rdata = s_q.line_format_reg[`UAC_LCR_DLAB] ? s_q.dlm : {4'h0, s_q.irq_enable_reg};
                `UAC_OFF_IIR: begin
                    s_d.rdata = iirVal;
                    if (iirVal == `UAC_IIR_TX_HOLDING_EMPTY_FLAG) begin
                        s_d.thriPend = 1'b0;
                    end
                end
                `UAC_OFF_LCR: s_d.rdata = s_q.line_format_reg;
                `UAC_OFF_MCR: s_d.rdata = {3'h0, s_q.mcr};
                `UAC_OFF_LSR: begin
                    s_d.rdata = lsrVal;
                    s_d.oe = 1'b0;
                    s_d.pe = 1'b0;
                    s_d.fe = 1'b0;
                    s_d.bi = 1'b0;
                end
                `UAC_OFF_MSR: begin
                    s_d.rdata = {mdmLvl, s_q.mdmDelta};
                    s_d.mdmDelta = 4'h0;
                end
                default: s_d.rdata = s_q.scr;
            endcase
        end

        // Transmitter, advanced once per tick of the sixteen-times clock.
        if (tick) begin
            s_d.txCnt = s_q.txCnt + 4'h1;
            case (s_q.txState)
                UAC_TX_IDLE: begin
                    s_d.txOut = 1'b1;
                    s_d.txCnt = 4'h0;
                    if (!s_q.thrEmpty) begin
                        s_d.tx_shift_reg = s_q.tx_holding_reg;
                        s_d.thrEmpty = 1'b1;
                        s_d.thriPend = 1'b1;
                        s_d.txOut = 1'b0;
                        s_d.txState = UAC_TX_START;
                    end
                end
                UAC_TX_START: begin
                    if (s_q.txCnt == `UAC_TICK_LAST) begin
                        s_d.txOut = s_q.tx_shift_reg[0];
                        s_d.txPar = s_q.tx_shift_reg[0];
                        s_d.tx_shift_reg = {1'b0, s_q.tx_shift_reg[7:1]};
                        s_d.txBit = 3'h0;
                        s_d.txState = UAC_TX_DATA;
                    end
                end
                UAC_TX_DATA: begin
                    if (s_q.txCnt == `UAC_TICK_LAST) begin
                        if (s_q.txBit == lastBit) begin
                            if (s_q.line_format_reg[`UAC_LCR_PAREN]) begin
                                s_d.txOut = txParBit;
                                s_d.txState = UAC_TX_PARITY;
                            end else begin
                                s_d.txOut = 1'b1;
                                s_d.txStop2 = s_q.line_format_reg[`UAC_LCR_STOP2];
                                s_d.txState = UAC_TX_STOP;
                            end
                        end else begin
                            s_d.txOut = s_q.tx_shift_reg[0];
                            s_d.txPar = s_q.txPar ^ s_q.tx_shift_reg[0];
                            s_d.tx_shift_reg = {1'b0, s_q.tx_shift_reg[7:1]};
                            s_d.txBit = s_q.txBit + 3'h1;
                        end
                    end
                end
                UAC_TX_PARITY: begin
                    if (s_q.txCnt == `UAC_TICK_LAST) begin
                        s_d.txOut = 1'b1;
                        s_d.txStop2 = s_q.line_format_reg[`UAC_LCR_STOP2];
                        s_d.txState = UAC_TX_STOP;
                    end
                end
                UAC_TX_STOP: begin
                    // When the line format stop-two bit is set, a second stop bit is sent for every word length.
                    if (s_q.txCnt == `UAC_TICK_LAST) begin
                        if (s_q.txStop2) begin
                            s_d.txStop2 = 1'b0;
                        end else begin
                            s_d.txState = UAC_TX_IDLE;
                        end
                    end
                end
                default: s_d.txState = UAC_TX_IDLE;
            endcase
        end

        // Receiver, sampling at mid-bit on the sixteen-times clock.
        if (tick) begin
            s_d.rxLast = rxLine;
            s_d.rxCnt = s_q.rxCnt + 4'h1;
            case (s_q.rxState)
                UAC_RX_IDLE: begin
                    s_d.rxCnt = 4'h0;
                    if (s_q.rxLast && !rxLine) begin
                        s_d.rxState = UAC_RX_START;
                    end
                end
                UAC_RX_START: begin
                    if (s_q.rxCnt == `UAC_TICK_MID) begin
                        s_d.rxCnt = 4'h0;
                        if (!rxLine) begin
                            s_d.rxBit = 3'h0;
                            s_d.rxPar = 1'b0;
                            s_d.rxZero = 1'b1;
                            s_d.rxState = UAC_RX_DATA;
                        end else begin
                            s_d.rxState = UAC_RX_IDLE;
                        end
                    end
                end
                UAC_RX_DATA: begin
                    if (s_q.rxCnt == `UAC_TICK_LAST) begin
                        s_d.rxShift = {rxLine, s_q.rxShift[7:1]};
                        s_d.rxPar = s_q.rxPar ^ rxLine;
                        s_d.rxZero = s_q.rxZero & ~rxLine;
                        s_d.rxBit = s_q.rxBit + 3'h1;
                        s_d.rxParBad = 1'b0;
                        if (s_q.rxBit == lastBit) begin
                            s_d.rxState = s_q.line_format_reg[`UAC_LCR_PAREN] ? UAC_RX_PARITY : UAC_RX_STOP;
                        end
                    end
                end
                UAC_RX_PARITY: begin
                    if (s_q.rxCnt == `UAC_TICK_LAST) begin
                        s_d.rxParBad = rxLine ^ rxParExp;
                        s_d.rxZero = s_q.rxZero & ~rxLine;
                        s_d.rxState = UAC_RX_STOP;
                    end
                end
                UAC_RX_STOP: begin
                    if (s_q.rxCnt == `UAC_TICK_LAST) begin
                        s_d.rxBuf = s_q.rxShift >> (`UAC_WLEN_PAD - s_q.line_format_reg[`UAC_LCR_WLEN]);
                        s_d.oe = s_d.oe | s_d.dr;
                        s_d.dr = 1'b1;
                        s_d.pe = s_d.pe | s_q.rxParBad;
                        s_d.fe = s_d.fe | ~rxLine;
                        s_d.bi = s_d.bi | (s_q.rxZero & ~rxLine);
                        s_d.rxState = UAC_RX_IDLE;
                    end
                end
                default: s_d.rxState = UAC_RX_IDLE;
            endcase
        end

        // Modem change detection; ring reports only its trailing edge.
        s_d.mdmPrev = mdmLvl;
        s_d.mdmDelta = s_d.mdmDelta | {mdmLvl[3] ^ s_q.mdmPrev[3], s_q.mdmPrev[2] & ~mdmLvl[2],
                                       mdmLvl[1:0] ^ s_q.mdmPrev[1:0]};

        // Pin and interrupt outputs.
        // Pins follow the new loop bit at once, so entering loopback never pulses a modem line.
        s_d.serOut = s_d.mcr[`UAC_MCR_LOOP] | (s_d.txOut & ~s_d.line_format_reg[`UAC_LCR_BREAK]);
        s_d.baudN = ~tick;
        s_d.rtsN = s_d.mcr[`UAC_MCR_LOOP] | ~s_d.mcr[`UAC_MCR_RTS];
        s_d.dtrN = s_d.mcr[`UAC_MCR_LOOP] | ~s_d.mcr[`UAC_MCR_DTR];
        s_d.out1N = s_d.mcr[`UAC_MCR_LOOP] | ~s_d.mcr[`UAC_MCR_OUT1];
        s_d.out2N = s_d.mcr[`UAC_MCR_LOOP] | ~s_d.mcr[`UAC_MCR_OUT2];
        s_d.irq = lineInt | rxInt | txInt | mdmInt;

        if (rst) begin
            s_d = '0;
            s_d.sin1 = 1'b1;
            s_d.sin2 = 1'b1;
            s_d.mdm1 = 4'hf;
            s_d.mdm2 = 4'hf;
            s_d.rxLast = 1'b1;
            s_d.irq_enable_reg = `UAC_IER_RESET;
            s_d.line_format_reg = `UAC_LCR_RESET;
            s_d.mcr = `UAC_MCR_RESET;
            s_d.scr = `UAC_SCR_RESET;
            s_d.dll = `UAC_DIV_RESET;
            s_d.dlm = `UAC_DIV_RESET;
            s_d.thrEmpty = 1'b1;
            s_d.txOut = 1'b1;
            s_d.txState = UAC_TX_IDLE;
            s_d.rxState = UAC_RX_IDLE;
            s_d.serOut = 1'b1;
            s_d.baudN = 1'b1;
            s_d.rtsN = 1'b1;
            s_d.dtrN = 1'b1;
            s_d.out1N = 1'b1;
            s_d.out2N = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hostRdata = s_q.rdata;
    assign serialOut = s_q.serOut;
    assign baudOutN = s_q.baudN;
    assign rtsN = s_q.rtsN;
    assign dtrN = s_q.dtrN;
    assign out1N = s_q.out1N;
    assign out2N = s_q.out2N;
    assign irqOut = s_q.irq;

endmodule : uac_core

// ### verif/uac_core_asserts.sv
// Checker of register port and serial line relations of the serial core.
`timescale 1ns/1ps
module uac_core_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostWdata,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostRdata,
    // Serial, modem and interrupt
    input wire logic serialOut,
    input wire logic baudOutN,
    input wire logic rtsN,
    input wire logic dtrN,
    input wire logic out1N,
    input wire logic out2N,
    input wire logic irqOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_scrWr; hostWrite && hostAddr == 3'h7; endsequence
    sequence s_scrRd; hostRead && hostAddr == 3'h7; endsequence
    property p_scratch; s_scrWr ##1 s_scrRd |=> hostRdata == $past(hostWdata, 2); endproperty
    a_scratch: assert property (p_scratch) else $error("scratch readback wrong");
    property p_rdIdle; !$past(hostRead) |-> hostRdata == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
    property p_iirCode;
        hostRead && hostAddr == 3'h2 |=> hostRdata inside {8'h01, 8'h06, 8'h04, 8'h02, 8'h00};
    endproperty
    a_iirCode: assert property (p_iirCode) else $error("bad ident code");
    property p_resetOuts;
        $fell(rst) |-> serialOut && baudOutN && rtsN && dtrN && out1N && out2N && !irqOut;
    endproperty
    a_resetOuts: assert property (p_resetOuts) else $error("outputs wrong after reset");
    property p_startLen; $fell(serialOut) |=> !serialOut [*8]; endproperty
    a_startLen: assert property (p_startLen) else $error("start bit too short");
    property p_ierMask; hostWrite && hostAddr == 3'h1 && hostWdata[3:0] == 4'h0 |-> ##2 !irqOut;
    endproperty
    a_ierMask: assert property (p_ierMask) else $error("masked interrupt shown");
    property p_mdmOut; hostWrite && hostAddr == 3'h4 && !hostWdata[4]
        |-> ##2 rtsN == !$past(hostWdata[1], 2) && dtrN == !$past(hostWdata[0], 2);
    endproperty
    a_mdmOut: assert property (p_mdmOut) else $error("modem outputs wrong");
    property p_loopOut; hostWrite && hostAddr == 3'h4 && hostWdata[4]
        |-> ##2 rtsN && dtrN && out1N && out2N;
    endproperty
    a_loopOut: assert property (p_loopOut) else $error("modem outputs active in loop");
endmodule : uac_core_chk

bind uac_core uac_core_chk u_chk (.clock(clock), .rst(rst), .hostAddr(hostAddr),
    .hostWdata(hostWdata), .hostWrite(hostWrite), .hostRead(hostRead), .hostRdata(hostRdata),
    .serialOut(serialOut), .baudOutN(baudOutN), .rtsN(rtsN), .dtrN(dtrN), .out1N(out1N),
    .out2N(out2N), .irqOut(irqOut));

// ### verif/uac_peer.sv
// Serial line partner that sends characters into the receive pin.
`timescale 1ns/1ps
module uac_peer (
    // Clock
    input wire logic clock,
    // Serial line, pulled high when idle
    output logic serialIn
);
    initial serialIn = 1'b1;
    task automatic sendByte(input logic [7:0] b, input int bitClk);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serialIn <= f[i];
            repeat (bitClk) @(posedge clock);
        end
    endtask : sendByte
    task automatic falseStart();
        serialIn <= 1'b0;
        repeat (4) @(posedge clock);
        serialIn <= 1'b1;
    endtask : falseStart
endmodule : uac_peer

// ### verif/uac_core_tb_top.sv
// Self-checking bench of the serial core against fixed expected values.
`timescale 1ns/1ps
module uac_core_tb_top;
    logic clock, hostWrite = 1'b0, hostRead = 1'b0, rst = 1'b1, ctsN = 1'b1, riN = 1'b1;
    logic [2:0] hostAddr = 3'h0;
    logic [7:0] hostWdata = 8'h00, hostRdata, r, d;
    logic serialIn, serialOut, baudOutN, rtsN, dtrN, out1N, out2N, irqOut;
    int failures = 0;
    int comparisons = 0;
    int n;
    logic [7:0] rxQ[$];
    localparam int DIV = 2;
    localparam int BITCLK = 16 * DIV;
    uac_core uut (.clock(clock), .rst(rst), .hostAddr(hostAddr), .hostWdata(hostWdata),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostRdata(hostRdata),
        .serialIn(serialIn), .serialOut(serialOut), .baudOutN(baudOutN), .ctsN(ctsN),
        .dsrN(1'b1), .dcdN(1'b1), .riN(riN), .rtsN(rtsN), .dtrN(dtrN), .out1N(out1N),
        .out2N(out2N), .irqOut(irqOut));
    uac_peer peer (.clock(clock), .serialIn(serialIn));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ------------------------------------------------------------------------
    // Bus, compare, capture and closing tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        // A write right after a write lets one edge pass, so the strobe is set once a step.
        if (hostWrite) @(posedge clock);
        hostWrite <= 1'b1;
        hostAddr <= a;
        hostWdata <= v;
        @(posedge clock);
        hostWrite <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
        hostRead <= 1'b1;
        hostAddr <= a;
        @(posedge clock);
        hostRead <= 1'b0;
        @(posedge clock);
        chk(hostRdata, exp);
    endtask : rdChk
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic txCapture(output logic [7:0] v);
        int n;
        n = 0;
        while (serialOut !== 1'b0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        if (n == 400) begin
            failures++;
            $display("BAD %0t no start bit", $time);
            results();
        end
        repeat (BITCLK / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BITCLK) @(posedge clock);
            v[i] = serialOut;
        end
    endtask : txCapture
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'h4cfc2658));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        d = 8'($urandom);
        wr(3'h7, d);
        rdChk(3'h7, d);
        wr(3'h3, 8'h83);
        wr(3'h0, 8'(DIV));
        wr(3'h1, 8'h00);
        rdChk(3'h0, 8'(DIV));
        rdChk(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h01);
        n = 0;
        repeat (32) begin
            @(posedge clock);
            if (!baudOutN) n++;
        end
        chk(8'(n), 8'(32 / DIV));
        $display("register test done");
        rdChk(3'h5, 8'h60);
        d = 8'($urandom);
        wr(3'h0, d);
        txCapture(r);
        chk(r, d);
        repeat (BITCLK) @(posedge clock);
        chk({7'h0, serialOut}, 8'h01);
        $display("transmit test done");
        ctsN <= 1'b0;
        riN <= 1'b0;
        repeat (6) @(posedge clock);
        rdChk(3'h6, 8'h51);
        rdChk(3'h6, 8'h50);
        riN <= 1'b1;
        repeat (6) @(posedge clock);
        rdChk(3'h6, 8'h14);
        $display("modem test done");
        peer.falseStart();
        repeat (11 * BITCLK) @(posedge clock);
        rdChk(3'h5, 8'h60);
        wr(3'h1, 8'h05);
        for (int i = 0; i < 2; i++) begin
            rxQ.push_back(8'($urandom));
            peer.sendByte(rxQ[i], BITCLK);
        end
        repeat (4) @(posedge clock);
        chk({7'h0, irqOut}, 8'h01);
        rdChk(3'h2, 8'h06);
        rdChk(3'h5, 8'h63);
        rdChk(3'h2, 8'h04);
        rdChk(3'h0, rxQ[1]);
        rdChk(3'h2, 8'h01);
        chk({7'h0, irqOut}, 8'h00);
        $display("receive test done");
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h00);
        d = 8'($urandom) | 8'he0;
        peer.sendByte(d, BITCLK);
        repeat (4) @(posedge clock);
        rdChk(3'h5, 8'h61);
        rdChk(3'h0, {3'h0, d[4:0]});
        peer.sendByte(8'h00, BITCLK);
        repeat (4) @(posedge clock);
        rdChk(3'h5, 8'h79);
        rdChk(3'h0, 8'h00);
        $display("format test done");
        wr(3'h4, 8'h13);
        repeat (3) @(posedge clock);
        chk({3'h0, serialOut, out2N, out1N, rtsN, dtrN}, 8'h1f);
        wr(3'h3, 8'h1b);
        d = 8'($urandom);
        wr(3'h0, d);
        repeat (12 * BITCLK) @(posedge clock);
        rdChk(3'h5, 8'h61);
        rdChk(3'h0, d);
        $display("loopback test done");
        results();
    end
endmodule : uac_core_tb_top
